// file: src/spec_compute_pkg.sv
// constants for the speculation and compute operation control bank
`default_nettype none
package spec_compute_pkg;
    // register byte offsets within the bank
    localparam logic [7:0] PLATFORM_CONTROL_OFS  = 8'h0c;
    localparam logic [7:0] COMPUTE_OP_CTRL_OFS   = 8'h40;
    // platform control fields
    localparam int         SPEC_DISABLE_BIT      = 15;
    localparam int         DATA_SPEC_ENABLE_BIT  = 14;
    // compute operation control fields
    localparam int         WAKE_ON_IRQ_BIT       = 2;
    localparam int         COMPUTE_ACK_BIT       = 1;
    localparam int         COMPUTE_REQUEST_BIT   = 0;
    // reset values
    localparam logic       SPEC_DISABLE_RST      = 1'b0;
    localparam logic       DATA_SPEC_ENABLE_RST  = 1'b0;
    localparam logic       WAKE_ON_IRQ_RST       = 1'b0;
    localparam logic       COMPUTE_REQUEST_RST   = 1'b0;
    // handshake state with the power logic
    typedef enum logic [1:0] {
        CPO_IDLE     = 2'b00,
        CPO_ENTERING = 2'b01,
        CPO_ACTIVE   = 2'b11,
        CPO_EXITING  = 2'b10
    } cpo_state_t;
endpackage
`default_nettype wire

// file: src/spec_compute_ctrl.sv
// register bank for flash speculation and compute operation control
`timescale 1ns/10ps
`default_nettype none
module spec_compute_ctrl
    import spec_compute_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [1:0]  avs_response,
    input  wire logic        vector_fetch,
    input  wire logic        entry_done,
    input  wire logic        exit_done,
    output logic             instr_spec_en,
    output logic             data_spec_en,
    output logic             compute_req_out
);

    // bus slave: one wait cycle, then answer with waitrequest low
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  resp_q, resp_d;
    logic        spec_disable_q, spec_disable_d;
    logic        data_spec_enable_q, data_spec_enable_d;
    logic        wake_on_irq_q, wake_on_irq_d;
    logic        compute_request_q, compute_request_d;
    logic        instr_spec_q, instr_spec_d;
    logic        data_spec_q, data_spec_d;
    cpo_state_t  state_q, state_d;
    logic        req_active;
    logic        wr_go;
    logic        hit_plat;
    logic        hit_cpo;

    assign req_active = (avs_read | avs_write) & ~ack_q;
    // commit in the answer cycle, the edge the master sees waitrequest low
    assign wr_go      = avs_write & ack_q;
    assign hit_plat   = avs_address == PLATFORM_CONTROL_OFS;
    assign hit_cpo    = avs_address == COMPUTE_OP_CTRL_OFS;

    always_comb
    begin
        ack_d   = req_active;
        rdata_d = 32'h0000_0000;
        resp_d  = 2'h0;
        if (req_active)
        begin
            if (hit_plat)
            begin
                rdata_d[SPEC_DISABLE_BIT]     = spec_disable_q;
                rdata_d[DATA_SPEC_ENABLE_BIT] = data_spec_enable_q;
            end
            else if (hit_cpo)
            begin
                rdata_d[WAKE_ON_IRQ_BIT]     = wake_on_irq_q;
                rdata_d[COMPUTE_ACK_BIT]     = state_q == CPO_ACTIVE
                                             || state_q == CPO_EXITING;
                rdata_d[COMPUTE_REQUEST_BIT] = compute_request_q;
            end
            else
            begin
                // unmapped words answer slave error, writes dropped
                resp_d = 2'h2;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            resp_q  <= 2'h0;
        end
        else
        begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
            resp_q  <= resp_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_response = resp_q;

    logic wait_q;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            wait_q <= 1'b1;
        else
            wait_q <= ~req_active;
    end
    assign avs_waitrequest = wait_q;

    // control registers; writes take effect at the answer edge
    always_comb
    begin
        spec_disable_d     = spec_disable_q;
        data_spec_enable_d = data_spec_enable_q;
        wake_on_irq_d      = wake_on_irq_q;
        compute_request_d  = compute_request_q;
        if (wr_go && hit_plat && avs_byteenable[1])
        begin
            spec_disable_d     = avs_writedata[SPEC_DISABLE_BIT];
            data_spec_enable_d = avs_writedata[DATA_SPEC_ENABLE_BIT];
        end
        if (wr_go && hit_cpo && avs_byteenable[0])
        begin
            // ack bit in the write data is ignored
            wake_on_irq_d     = avs_writedata[WAKE_ON_IRQ_BIT];
            compute_request_d = avs_writedata[COMPUTE_REQUEST_BIT];
        end
        // vector fetch wins over a same-cycle software set
        if (wake_on_irq_q && vector_fetch)
            compute_request_d = 1'b0;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            spec_disable_q     <= SPEC_DISABLE_RST;
            data_spec_enable_q <= DATA_SPEC_ENABLE_RST;
            wake_on_irq_q      <= WAKE_ON_IRQ_RST;
            compute_request_q  <= COMPUTE_REQUEST_RST;
        end
        else
        begin
            spec_disable_q     <= spec_disable_d;
            data_spec_enable_q <= data_spec_enable_d;
            wake_on_irq_q      <= wake_on_irq_d;
            compute_request_q  <= compute_request_d;
        end
    end

    // speculation outputs
    always_comb
    begin
        instr_spec_d = ~spec_disable_q;
        data_spec_d  = ~spec_disable_q & data_spec_enable_q;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            instr_spec_q <= 1'b1;
            data_spec_q  <= 1'b0;
        end
        else
        begin
            instr_spec_q <= instr_spec_d;
            data_spec_q  <= data_spec_d;
        end
    end

    assign instr_spec_en   = instr_spec_q;
    assign data_spec_en    = data_spec_q;
    assign compute_req_out = compute_request_q;

    // entry/exit handshake with power logic
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            CPO_IDLE:
                if (compute_request_q)
                    state_d = CPO_ENTERING;
            CPO_ENTERING:
                if (entry_done)
                    state_d = CPO_ACTIVE;
            CPO_ACTIVE:
                if (!compute_request_q)
                    state_d = CPO_EXITING;
            CPO_EXITING:
                if (exit_done)
                    state_d = CPO_IDLE;
            default:
                state_d = CPO_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            state_q <= CPO_IDLE;
        else
            state_q <= state_d;
    end

    property p_ack_reads_state;
        @(posedge mclk) disable iff (!rstn)
        (avs_read && req_active && hit_cpo) |=>
            avs_readdata[COMPUTE_ACK_BIT] ==
            ($past(state_q) inside {CPO_ACTIVE, CPO_EXITING});
    endproperty
    a_ack_reads_state: assert property (p_ack_reads_state)
        else $error("ack bit disagrees with handshake state");

    property p_reserved_zero;
        @(posedge mclk) disable iff (!rstn)
        !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000
            && avs_readdata[13:3] == 11'h000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_disable_overrides;
        @(posedge mclk) disable iff (!rstn)
        spec_disable_q |=> !instr_spec_en && !data_spec_en;
    endproperty
    a_disable_overrides: assert property (p_disable_overrides)
        else $error("speculation on while disabled");

    property p_data_follows;
        @(posedge mclk) disable iff (!rstn)
        !spec_disable_q |=> instr_spec_en
            && data_spec_en == $past(data_spec_enable_q);
    endproperty
    a_data_follows: assert property (p_data_follows)
        else $error("data speculation not following enable");

    property p_auto_clear;
        @(posedge mclk) disable iff (!rstn)
        (wake_on_irq_q && vector_fetch) |=> !compute_req_out;
    endproperty
    a_auto_clear: assert property (p_auto_clear)
        else $error("request not cleared on vector fetch");

    property p_no_clear_without_woi;
        @(posedge mclk) disable iff (!rstn)
        (compute_request_q && !wake_on_irq_q && !wr_go) |=>
            compute_req_out;
    endproperty
    a_no_clear_without_woi: assert property (p_no_clear_without_woi)
        else $error("request dropped with no cause");

    property p_write_disable;
        @(posedge mclk) disable iff (!rstn)
        (wr_go && hit_plat && avs_byteenable[1]
            && avs_writedata[SPEC_DISABLE_BIT]) |=> ##1 !instr_spec_en;
    endproperty
    a_write_disable: assert property (p_write_disable)
        else $error("disable write did not stop speculation");

    sequence s_idle_req;
        state_q == CPO_IDLE && compute_request_q;
    endsequence
    property p_entry_start;
        @(posedge mclk) disable iff (!rstn)
        s_idle_req |=> state_q == CPO_ENTERING;
    endproperty
    a_entry_start: assert property (p_entry_start)
        else $error("entry not started on request");

    property p_ack_write_ignored;
        @(posedge mclk) disable iff (!rstn)
        (wr_go && hit_cpo && !entry_done
            && state_q inside {CPO_IDLE, CPO_ENTERING}) |=>
            !(state_q inside {CPO_ACTIVE, CPO_EXITING});
    endproperty
    a_ack_write_ignored: assert property (p_ack_write_ignored)
        else $error("write disturbed handshake");

    property p_bus_answer;
        @(posedge mclk) disable iff (!rstn)
        ($rose(avs_read) || $rose(avs_write)) |-> ##1 !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer late");

endmodule
`default_nettype wire

// file: verif/spec_compute_ctrl_tb.sv
// self-checking bench for the speculation and compute control bank
`timescale 1ns/10ps
`default_nettype none
module spec_compute_ctrl_tb;
    import spec_compute_pkg::*;

    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic        vector_fetch = 1'b0;
    logic        entry_done = 1'b0;
    logic        exit_done = 1'b0;
    logic        instr_spec_en;
    logic        data_spec_en;
    logic        compute_req_out;
    int          errors = 0;
    int          samples_checked = 0;
    logic [31:0] d;
    logic [31:0] rd;
    logic [3:0]  b;
    logic [1:0]  rs;
    logic        sd;
    logic        de;
    int          i;

    spec_compute_ctrl uut (
        .mclk            (mclk),
        .rstn            (rstn),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .avs_response    (avs_response),
        .vector_fetch    (vector_fetch),
        .entry_done      (entry_done),
        .exit_done       (exit_done),
        .instr_spec_en   (instr_spec_en),
        .data_spec_en    (data_spec_en),
        .compute_req_out (compute_req_out)
    );

    always #20 mclk = ~mclk;

    function automatic logic [31:0] plc(input logic s, input logic e);
        plc = 32'h0;
        plc[SPEC_DISABLE_BIT] = s;
        plc[DATA_SPEC_ENABLE_BIT] = e;
    endfunction

    function automatic logic [31:0] cpo(input logic w, input logic a,
                                        input logic r);
        cpo = 32'h0;
        cpo[WAKE_ON_IRQ_BIT] = w;
        cpo[COMPUTE_ACK_BIT] = a;
        cpo[COMPUTE_REQUEST_BIT] = r;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task close_out;
        if (errors == 0 && samples_checked > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // request held until waitrequest is seen low; a hang ends at the watchdog
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] dt, input logic [3:0] be);
        @(posedge mclk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= dt;
        avs_byteenable <= be;
        do
        begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rs = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic hold_in(input int which, input int cyc);
        @(posedge mclk);
        if (which == 0) entry_done <= 1'b1;
        else if (which == 1) exit_done <= 1'b1;
        else vector_fetch <= 1'b1;
        repeat (cyc) @(posedge mclk);
        entry_done <= 1'b0;
        exit_done <= 1'b0;
        vector_fetch <= 1'b0;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        errors++;
        $display("Error at %0t: watchdog expired", $time);
        close_out();
    end

    initial
    begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        d = $urandom(32'h55e9);
        sd = 1'b0;
        de = 1'b0;
        bus(0, PLATFORM_CONTROL_OFS, 32'h0, 4'hf);
        chk(rd, 32'h0);
        chk({31'h0, instr_spec_en}, 32'h1);
        chk({31'h0, data_spec_en}, 32'h0);
        bus(0, COMPUTE_OP_CTRL_OFS, 32'h0, 4'hf);
        chk(rd, 32'h0);
        // fixed combinations first, then random data and lanes
        for (i = 0; i < 24; i++)
        begin
            d = (i < 4) ? {16'h0, i[1:0], 14'h0} : $urandom;
            b = (i < 4) ? 4'hf : 4'($urandom);
            bus(1, PLATFORM_CONTROL_OFS, d, b);
            if (b[1])
            begin
                sd = d[15];
                de = d[14];
            end
            bus(0, PLATFORM_CONTROL_OFS, 32'h0, 4'hf);
            chk(rd, plc(sd, de));
            chk({31'h0, instr_spec_en}, {31'h0, !sd});
            chk({31'h0, data_spec_en}, {31'h0, !sd && de});
        end
        bus(1, 8'h20, 32'hffff_ffff, 4'hf);
        chk({30'h0, rs}, 32'h2);
        bus(0, 8'h20, 32'h0, 4'hf);
        chk(rd, 32'h0);
        bus(0, PLATFORM_CONTROL_OFS, 32'h0, 4'hf);
        chk(rd, plc(sd, de));
        // ack written as 1 with the request must stay 0 until entry ends
        bus(1, COMPUTE_OP_CTRL_OFS, 32'hffff_fffb, 4'hf);
        bus(0, COMPUTE_OP_CTRL_OFS, 32'h0, 4'hf);
        chk(rd, cpo(0, 0, 1));
        chk({31'h0, compute_req_out}, 32'h1);
        hold_in(0, 3);
        bus(0, COMPUTE_OP_CTRL_OFS, 32'h0, 4'hf);
        chk(rd, cpo(0, 1, 1));
        bus(1, COMPUTE_OP_CTRL_OFS, 32'h0, 4'hf);
        bus(0, COMPUTE_OP_CTRL_OFS, 32'h0, 4'hf);
        chk(rd, cpo(0, 1, 0));
        chk({31'h0, compute_req_out}, 32'h0);
        hold_in(1, 3);
        bus(0, COMPUTE_OP_CTRL_OFS, 32'h0, 4'hf);
        chk(rd, cpo(0, 0, 0));
        // vector fetch with and without the wake bit
        bus(1, COMPUTE_OP_CTRL_OFS, 32'h5, 4'hf);
        hold_in(2, 1);
        bus(0, COMPUTE_OP_CTRL_OFS, 32'h0, 4'hf);
        chk(rd, cpo(1, 0, 0));
        chk({31'h0, compute_req_out}, 32'h0);
        hold_in(0, 3);
        hold_in(1, 3);
        bus(1, COMPUTE_OP_CTRL_OFS, 32'h1, 4'hf);
        hold_in(2, 1);
        bus(0, COMPUTE_OP_CTRL_OFS, 32'h0, 4'hf);
        chk(rd, cpo(0, 0, 1));
        chk({31'h0, compute_req_out}, 32'h1);
        bus(1, COMPUTE_OP_CTRL_OFS, 32'h0, 4'hf);
        hold_in(0, 3);
        hold_in(1, 3);
        bus(0, COMPUTE_OP_CTRL_OFS, 32'h0, 4'hf);
        chk(rd, cpo(0, 0, 0));
        close_out();
    end
endmodule
`default_nettype wire
